//--- sim/pucfm_osc_model.sv
// Behavioural primary oscillator and low-power RC time base
`default_nettype none
module pucfm_osc_model #(
	parameter int LOW_POWER_RC_OSCILLATOR_DIV = 8
) (
	input  wire logic mclk,        // System clock
	input  wire logic primary_oscillator_run,    // Primary crystal oscillating
	input  wire logic primary_oscillator_ok,     // Start-up criteria reached
	output logic      primary_oscillator_tick,   // Primary activity pulse
	output logic      primary_oscillator_stable, // Primary stable level
	output logic      low_power_rc_oscillator_tick    // Low-power RC period pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	int lp_cnt;
	initial begin
		lp_cnt = 0;
		primary_oscillator_tick = 1'b0;
		primary_oscillator_stable = 1'b0;
		low_power_rc_oscillator_tick = 1'b0;
	end
	// Free-running RC, unlike the crystal which can die at any time
	always @(posedge mclk) begin
		lp_cnt <= (lp_cnt + 1) % LOW_POWER_RC_OSCILLATOR_DIV;
		low_power_rc_oscillator_tick <= (lp_cnt == LOW_POWER_RC_OSCILLATOR_DIV - 1);
		primary_oscillator_tick <= primary_oscillator_run & ~primary_oscillator_tick;
		primary_oscillator_stable <= primary_oscillator_run & primary_oscillator_ok;
	end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the clock divider, USB select and fail-safe monitor
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import pucfm_pkg::*;
	localparam int LOCK_T = 4;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        wake_evt = 1'b0;
	logic        pb_access = 1'b0;
	logic        usb_suspend = 1'b0;
	logic        usb_activity = 1'b0;
	logic        primary_oscillator_run = 1'b1;
	logic        primary_oscillator_ok = 1'b1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pb_clk_en;
	logic        cpu_stall;
	logic [2:0]  sys_src;
	pucfm_usb_t  usb_out;
	wire logic   primary_oscillator_tick;
	wire logic   primary_oscillator_stable;
	wire logic   low_power_rc_oscillator_tick;
	int          miscompares = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        err;
	logic [31:0] pulses;

	always #10 mclk = ~mclk;

	pucfm_top #(.LOCK_CYC(LOCK_T), .DELAY_TK(2), .WIN_TK(2)) dut_u (
		.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wake_evt(wake_evt), .primary_oscillator_tick(primary_oscillator_tick),
		.primary_oscillator_stable(primary_oscillator_stable), .low_power_rc_oscillator_tick(low_power_rc_oscillator_tick), .pb_access(pb_access),
		.usb_suspend(usb_suspend), .usb_activity(usb_activity), .pb_clk_en(pb_clk_en),
		.cpu_stall(cpu_stall), .sys_src(sys_src), .usb_out(usb_out));

	pucfm_osc_model osc_u (.mclk(mclk), .primary_oscillator_run(primary_oscillator_run), .primary_oscillator_ok(primary_oscillator_ok),
		.primary_oscillator_tick(primary_oscillator_tick), .primary_oscillator_stable(primary_oscillator_stable), .low_power_rc_oscillator_tick(low_power_rc_oscillator_tick));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, pready}, 32'h1, "apb ready");
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e, "register read");
	endtask

	task automatic wake();
		@(posedge mclk);
		wake_evt <= 1'b1;
		@(posedge mclk);
		wake_evt <= 1'b0;
	endtask

	task automatic wait_src(input logic [2:0] s);
		int n;
		n = 0;
		while (sys_src !== s && n < 400) begin
			@(posedge mclk);
			n++;
		end
		@(negedge mclk);
		chk({29'h0, sys_src}, {29'h0, s}, "current source");
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		repeat (4) @(posedge mclk);
		rdchk(ADDR_CFG_ONE, 32'hffffffff, C1_RESET);
		rdchk(ADDR_CFG_TWO, 32'hffffffff, C2_RESET);
		rdchk(ADDR_OSC_CTRL, 32'h00007040, 32'h00002000);
		chk({30'h0, usb_out.src}, {30'h0, USB_SRC_PRIMARY_OSCILLATOR}, "usb source primary");
		rdchk(8'hfc, 32'hffffffff, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, ADDR_IRQ_PRI, 32'hffffffff);
		rdchk(ADDR_IRQ_PRI, 32'h00001f00, 32'h00001f00);
		apb(1'b1, ADDR_IRQ_EN, 32'h0);
		$display("test reset_and_map done");
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, ADDR_OSC_CTRL, 32'(d) << OC_PB_LO);
			repeat (16) @(posedge mclk);
			pulses = 32'h0;
			repeat (64) begin
				@(posedge mclk);
				pulses += {31'h0, pb_clk_en};
			end
			chk(pulses, 32'd64 >> d, "pb enable count");
		end
		$display("test divider done");
		for (int d = 1; d >= 0; d--) begin
			apb(1'b1, ADDR_OSC_CTRL, 32'(d) << OC_PB_LO);
			@(posedge mclk);
			pb_access <= 1'b1;
			// First access arms the wait; the held second one shows the stall
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			chk({31'h0, cpu_stall}, 32'(d), "stall on back-to-back");
			@(posedge mclk);
			pb_access <= 1'b0;
			repeat (20) @(posedge mclk);
		end
		$display("test stall done");
		apb(1'b1, ADDR_CFG_TWO, 32'h00008101);
		repeat (LOCK_T + 10) @(posedge mclk);
		rdchk(ADDR_OSC_CTRL, 32'h00000040, 32'h0);
		apb(1'b1, ADDR_CFG_ONE, 32'h00004003);
		wake();
		wait_src(OSC_PRIMARY_OSCILLATOR_PLL);
		repeat (LOCK_T + 10) @(posedge mclk);
		rdchk(ADDR_OSC_CTRL, 32'h00000040, 32'h00000040);
		chk({30'h0, usb_out.src, usb_out.pll_div2}, 32'h5, "usb pll halved");
		apb(1'b1, ADDR_OSC_CTRL, 32'h00000004);
		usb_suspend <= 1'b1;
		usb_activity <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({29'h0, usb_out.src, usb_out.wake}, 32'h1, "usb rc wake");
		usb_suspend <= 1'b0;
		usb_activity <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({30'h0, usb_out.src}, {30'h0, USB_SRC_PLL}, "usb back to 48");
		$display("test usb done");
		apb(1'b1, ADDR_CFG_ONE, 32'h00000002);
		wake();
		wait_src(OSC_PRIMARY_OSCILLATOR);
		apb(1'b1, ADDR_OSC_CTRL, 32'h00000001);
		primary_oscillator_run <= 1'b0;
		wait_src(OSC_FRC);
		rdchk(ADDR_OSC_CTRL, 32'h00007009, 32'h00000008);
		rdchk(ADDR_IRQ_FLAG, 32'h00004000, 32'h00004000);
		primary_oscillator_run <= 1'b1;
		wake();
		repeat (50) @(posedge mclk);
		chk({29'h0, sys_src}, {29'h0, OSC_FRC}, "stays on rc");
		$display("test monitor done");
		@(posedge mclk);
		srst <= 1'b1;
		primary_oscillator_run <= 1'b0;
		primary_oscillator_ok <= 1'b0;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		apb(1'b1, ADDR_CFG_ONE, 32'h00004002);
		wake();
		repeat (100) @(posedge mclk);
		rdchk(ADDR_OSC_CTRL, 32'h00007008, 32'h0);
		apb(1'b1, ADDR_CFG_ONE, 32'h00000002);
		wake();
		rd = 32'h0;
		for (int n = 0; n < 40 && rd[OC_CF] !== 1'b1; n++) begin
			apb(1'b0, ADDR_OSC_CTRL, 32'h0);
		end
		chk(rd & 32'h00007008, 32'h00000008, "slow start failure");
		rdchk(ADDR_IRQ_FLAG, 32'h00004000, 32'h00004000);
		$display("test slow_start done");
		wrap_up();
	end
endmodule
`default_nettype wire

//--- src/pucfm_pkg.sv
// Package with register map, field layout and codes for the clock monitor block
`default_nettype none
package pucfm_pkg;
	localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IRQ_FLAG = 8'h04;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h08;
	localparam logic [7:0] ADDR_IRQ_PRI  = 8'h0c;
	localparam logic [7:0] ADDR_CFG_ONE  = 8'h10;
	localparam logic [7:0] ADDR_CFG_TWO  = 8'h14;
	// osc_control_reg fields
	localparam int OC_PB_LO   = 19;
	localparam int OC_PB_HI   = 20;
	localparam int OC_CURRENT_OSC_SELECT_LO = 12;
	localparam int OC_CURRENT_OSC_SELECT_HI = 14;
	localparam int OC_NEW_OSC_SELECT_LO = 8;
	localparam int OC_NEW_OSC_SELECT_HI = 10;
	localparam int OC_LOCK    = 6;
	localparam int OC_CF      = 3;
	localparam int OC_URC     = 2;
	localparam int OC_SWREQ   = 0;
	// Interrupt control fields
	localparam int IRQ_BIT    = 14;
	localparam int PRI_LO     = 10;
	localparam int PRI_HI     = 12;
	localparam int SUB_LO     = 8;
	localparam int SUB_HI     = 9;
	// Configuration word fields
	localparam int C1_DEFAULT_OSC_CONFIG_LO = 0;
	localparam int C1_DEFAULT_OSC_CONFIG_HI = 2;
	localparam int C1_SM_LO    = 14;
	localparam int C1_SM_HI    = 15;
	localparam logic [31:0] C1_MASK = 32'h0000c007;
	localparam logic [31:0] C2_MASK = 32'h0007ff77;
	localparam int C2_UDIV_LO  = 8;
	localparam int C2_UDIV_HI  = 10;
	localparam int C2_UEN      = 15;
	// Reset values: switching and monitor off, primary oscillator default
	localparam logic [31:0] C1_RESET = 32'h0000c002;
	localparam logic [31:0] C2_RESET = 32'h00000000;
	// Switching/monitor configuration codes
	localparam logic [1:0] SM_BOTH   = 2'h0;
	localparam logic [1:0] SM_SWONLY = 2'h1;
	// Current oscillator codes
	localparam logic [2:0] OSC_FRC      = 3'h0;
	localparam logic [2:0] OSC_FRC_PLL  = 3'h1;
	localparam logic [2:0] OSC_PRIMARY_OSCILLATOR     = 3'h2;
	localparam logic [2:0] OSC_PRIMARY_OSCILLATOR_PLL = 3'h3;
	localparam logic [2:0] OSC_LOW_POWER_RC_OSCILLATOR     = 3'h4;
	localparam logic [2:0] OSC_FRC_DIV  = 3'h7;
	// Timing
	localparam int CLK_NS        = 20;
	localparam int USB_LOCK_NS   = 2000;
	localparam int USB_LOCK_CYC  = (USB_LOCK_NS + CLK_NS - 1) / CLK_NS;
	localparam int PB_SYNC_CYC   = 2;
	localparam int MON_DELAY_TK  = 16;
	localparam int FAIL_WIN_TK   = 2;
	typedef enum logic [1:0] {
		USB_SRC_FRC  = 2'h0,
		USB_SRC_PRIMARY_OSCILLATOR = 2'h1,
		USB_SRC_PLL  = 2'h2
	} pucfm_usb_src_t;
	typedef struct packed {
		pucfm_usb_src_t src;
		logic           pll_div2;
		logic           wake;
	} pucfm_usb_t;
	typedef enum logic [3:0] {
		MON_OFF    = 4'h1,
		MON_DELAY  = 4'h2,
		MON_WATCH  = 4'h4,
		MON_FAILED = 4'h8
	} pucfm_mon_t;
endpackage
`default_nettype wire

//--- src/pucfm_top.sv
// Peripheral bus divider, USB clock select, two-speed start-up and fail-safe monitor
// How it works
// - Peripheral bus enable pulses at system rate divided by 1, 2, 4 or 8.
// - Peripheral bus never faster than system clock; 1:1 pulses every cycle.
// - Back-to-back peripheral accesses stall the CPU unless ratio is 1:1.
// - Divider only gates the bus enable; system-clock logic unaffected.
// - USB clock from RC, 48 MHz primary, or PLL divided by two.
// - RC clock serves USB only in suspend for wake detect; code holds RC after suspend until an enabled USB PLL locks.
// - Read-only USB PLL lock flag set after nominal lock delay.
// - Lock flag cleared at reset and while no PLL source selected.
// - Two-speed start runs on RC until primary oscillator is stable.
// - Config bits 15:14 enable two-speed and monitor; current source shown.
// - Detected failure forces RC source until reset.
// - Failure loads current source 000, sets fail flag, clears switch request.
// - Failure sets interrupt flag; switch happens even with enable clear.
// - Priority at bits 12:10 and subpriority at bits 9:8.
// - Config 01 switching only; 00 switching plus monitor.
// - Default source 010 primary, 011 primary with PLL.
// - Monitor start delay counts only after internal reset release or wake.
// - Start delay applies only with monitor on and crystal or secondary source.
// - Delay expiring before a slow oscillator starts raises a failure.
// - Source codes: RC with PLL 001, low-power RC 100, divided RC 111.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`default_nettype none
module pucfm_top
	import pucfm_pkg::*;
#(
	parameter int         LOCK_CYC  = pucfm_pkg::USB_LOCK_CYC,
	parameter int         DELAY_TK  = pucfm_pkg::MON_DELAY_TK,
	parameter int         WIN_TK    = pucfm_pkg::FAIL_WIN_TK,
	parameter logic [2:0] SECONDARY_OSCILLATOR_CODE = 3'h5
) (
	input  wire logic        mclk,        // System clock, 50 MHz
	input  wire logic        srst,        // Internal system reset
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB access phase
	input  wire logic        pwrite,      // APB write
	input  wire logic [7:0]  paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	output logic      [31:0] prdata,      // APB read data
	output logic             pready,      // APB ready
	output logic             pslverr,     // APB unmapped address
	input  wire logic        wake_evt,    // Exit from sleep
	input  wire logic        primary_oscillator_tick,   // Primary oscillator activity pulse
	input  wire logic        primary_oscillator_stable, // Primary start-up criteria met
	input  wire logic        low_power_rc_oscillator_tick,   // Low-power RC time base pulse
	input  wire logic        pb_access,   // CPU peripheral register access
	input  wire logic        usb_suspend, // USB module in suspend
	input  wire logic        usb_activity,// Bus activity seen in suspend
	output logic             pb_clk_en,   // Peripheral bus clock enable
	output logic             cpu_stall,   // CPU stall request
	output logic      [2:0]  sys_src,     // Current system clock source
	output var pucfm_pkg::pucfm_usb_t usb_out // USB clock selection
);
	import pucfm_pkg::*;

	logic [31:0] cfg1_reg, cfg2_reg;
	logic [1:0]  pb_div_reg;
	logic [2:0]  new_osc_select_reg, current_osc_select_reg;
	logic        cf_reg, urc_reg, swreq_reg, lock_reg;
	logic        irqf_reg, irqe_reg;
	logic [4:0]  pri_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg, pslverr_reg;
	logic [2:0]  pb_cnt_reg;
	logic        pb_en_reg, wait_edge_reg, stall_reg;
	logic [1:0]  sync_cnt_reg;
	logic        started_reg, ts_pend_reg;
	pucfm_mon_t  mon_reg, mon_next;
	logic [15:0] dly_cnt_reg, win_cnt_reg, lock_cnt_reg;
	pucfm_usb_t  usb_reg;

	// Bus decode
	wire setup  = psel && !penable;
	wire wr_en  = psel && penable && pwrite && pready_reg;
	wire hit_oc = paddr == ADDR_OSC_CTRL;
	wire hit_if = paddr == ADDR_IRQ_FLAG;
	wire hit_ie = paddr == ADDR_IRQ_EN;
	wire hit_ip = paddr == ADDR_IRQ_PRI;
	wire hit_c1 = paddr == ADDR_CFG_ONE;
	wire hit_c2 = paddr == ADDR_CFG_TWO;
	wire mapped = hit_oc | hit_if | hit_ie | hit_ip | hit_c1 | hit_c2;

	// Configuration decode
	wire [1:0] sm_cfg   = cfg1_reg[C1_SM_HI:C1_SM_LO];
	wire [2:0] dflt_osc = cfg1_reg[C1_DEFAULT_OSC_CONFIG_HI:C1_DEFAULT_OSC_CONFIG_LO];
	wire sw_en    = (sm_cfg == SM_SWONLY) || (sm_cfg == SM_BOTH);
	wire mon_en   = sm_cfg == SM_BOTH;
	wire dflt_pos = (dflt_osc == OSC_PRIMARY_OSCILLATOR) || (dflt_osc == OSC_PRIMARY_OSCILLATOR_PLL);
	wire two_spd  = sw_en && dflt_pos;
	wire dly_src  = dflt_pos || (dflt_osc == SECONDARY_OSCILLATOR_CODE);
	wire use_dly  = mon_en && dly_src;
	wire usb_pll_en  = cfg2_reg[C2_UEN];
	wire pll_used = (current_osc_select_reg == OSC_FRC_PLL) || (current_osc_select_reg == OSC_PRIMARY_OSCILLATOR_PLL);
	wire pll_in   = usb_pll_en && pll_used;
	wire cur_primary_oscillator = (current_osc_select_reg == OSC_PRIMARY_OSCILLATOR) || (current_osc_select_reg == OSC_PRIMARY_OSCILLATOR_PLL);
	// First cycle after internal reset release, or wake from sleep
	wire restart  = !started_reg || wake_evt;

	wire [31:0] oc_rd = {11'h000, pb_div_reg, 4'h0, current_osc_select_reg, 1'b0, new_osc_select_reg,
		1'b0, lock_reg, 2'h0, cf_reg, urc_reg, 1'b0, swreq_reg};
	wire [31:0] rd_mux =
		hit_oc ? oc_rd :
		hit_if ? (32'(irqf_reg) << IRQ_BIT) :
		hit_ie ? (32'(irqe_reg) << IRQ_BIT) :
		hit_ip ? (32'(pri_reg) << SUB_LO) :
		hit_c1 ? cfg1_reg :
		hit_c2 ? cfg2_reg : 32'h0;

	// Peripheral bus divider
	wire [2:0] pb_mask = 3'((4'h1 << pb_div_reg) - 4'h1);
	// Counter runs past the mask after a ratio change, so compare with >=
	wire pb_hit  = pb_cnt_reg >= pb_mask;
	wire pb_busy = wait_edge_reg || (sync_cnt_reg != 2'h0);

	// Monitor
	// Failure is sticky: only srst leaves it, a wake does not
	wire dly_done = dly_cnt_reg >= 16'(DELAY_TK);
	wire win_done = win_cnt_reg >= 16'(WIN_TK);
	logic mon_fail;
	always_comb begin
		mon_next = mon_reg;
		mon_fail = 1'b0;
		case (mon_reg)
			MON_OFF: begin
				if (restart && mon_en)
					mon_next = use_dly ? MON_DELAY : MON_WATCH;
			end
			MON_DELAY: begin
				if (primary_oscillator_stable)
					mon_next = MON_WATCH;
				else if (dly_done) begin
					mon_next = MON_FAILED;
					mon_fail = 1'b1;
				end
			end
			MON_WATCH: begin
				if (!mon_en)
					mon_next = MON_OFF;
				else if (cur_primary_oscillator && win_done) begin
					mon_next = MON_FAILED;
					mon_fail = 1'b1;
				end
			end
			MON_FAILED: mon_next = MON_FAILED;
			default: mon_next = MON_OFF;
		endcase
	end
	wire ts_done = ts_pend_reg && primary_oscillator_stable && !mon_fail && mon_reg != MON_FAILED;

	wire [1:0]  usb_sel  = (usb_suspend && urc_reg) ? USB_SRC_FRC :
		(usb_pll_en ? USB_SRC_PLL : USB_SRC_PRIMARY_OSCILLATOR);
	wire usb_ok = usb_sel != USB_SRC_PLL || lock_reg;

	// APB slave: setup cycle loads the answer, access cycle completes
	// No wait states: pready always follows setup by exactly one cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && !mapped;
			prdata_reg  <= setup ? rd_mux : 32'h0;
		end
	end

	// Software registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			cfg1_reg   <= C1_RESET;
			cfg2_reg   <= C2_RESET;
			pb_div_reg <= 2'h0;
			new_osc_select_reg   <= OSC_FRC;
			urc_reg    <= 1'b0;
			irqe_reg   <= 1'b0;
			pri_reg    <= 5'h00;
		end else if (wr_en) begin
			if (hit_c1)
				cfg1_reg <= pwdata & C1_MASK;
			if (hit_c2)
				cfg2_reg <= pwdata & C2_MASK;
			if (hit_oc) begin
				pb_div_reg <= pwdata[OC_PB_HI:OC_PB_LO];
				new_osc_select_reg   <= pwdata[OC_NEW_OSC_SELECT_HI:OC_NEW_OSC_SELECT_LO];
				urc_reg    <= pwdata[OC_URC];
			end
			if (hit_ie)
				irqe_reg <= pwdata[IRQ_BIT];
			if (hit_ip)
				pri_reg <= pwdata[PRI_HI:SUB_LO];
		end
	end

	// Hardware-set flags: a failure in the clearing cycle wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			cf_reg    <= 1'b0;
			irqf_reg  <= 1'b0;
			swreq_reg <= 1'b0;
		end else begin
			if (mon_fail)
				cf_reg <= 1'b1;
			else if (wr_en && hit_oc)
				cf_reg <= pwdata[OC_CF];
			if (mon_fail)
				irqf_reg <= 1'b1;
			else if (wr_en && hit_if)
				irqf_reg <= pwdata[IRQ_BIT];
			// Held low while switching is disabled
			if (mon_fail || !sw_en)
				swreq_reg <= 1'b0;
			else if (wr_en && hit_oc)
				swreq_reg <= pwdata[OC_SWREQ];
		end
	end

	// Divider and stall; system-clock logic never sees the enable
	always_ff @(posedge mclk) begin
		if (srst) begin
			pb_cnt_reg    <= 3'h0;
			pb_en_reg     <= 1'b0;
			wait_edge_reg <= 1'b0;
			sync_cnt_reg  <= 2'h0;
			stall_reg     <= 1'b0;
		end else begin
			pb_cnt_reg <= pb_hit ? 3'h0 : 3'(pb_cnt_reg + 3'h1);
			pb_en_reg  <= pb_hit;
			if (pb_access && pb_div_reg != 2'h0 && !pb_busy)
				wait_edge_reg <= 1'b1;
			else if (wait_edge_reg && pb_hit)
				wait_edge_reg <= 1'b0;
			if (wait_edge_reg && pb_hit)
				sync_cnt_reg <= 2'(PB_SYNC_CYC);
			else if (sync_cnt_reg != 2'h0)
				sync_cnt_reg <= 2'(sync_cnt_reg - 2'h1);
			stall_reg <= pb_access && pb_busy && pb_div_reg != 2'h0;
		end
	end

	// Current source, two-speed start-up and monitor counters
	always_ff @(posedge mclk) begin
		if (srst) begin
			started_reg <= 1'b0;
			ts_pend_reg <= 1'b0;
			current_osc_select_reg    <= OSC_FRC;
			mon_reg     <= MON_OFF;
			dly_cnt_reg <= 16'h0;
			win_cnt_reg <= 16'h0;
		end else begin
			started_reg <= 1'b1;
			mon_reg     <= mon_next;
			if (mon_fail || mon_reg == MON_FAILED) begin
				current_osc_select_reg    <= OSC_FRC;
				ts_pend_reg <= 1'b0;
			end else if (restart) begin
				current_osc_select_reg    <= two_spd ? OSC_FRC : dflt_osc;
				ts_pend_reg <= two_spd;
			end else if (ts_done) begin
				current_osc_select_reg    <= dflt_osc;
				ts_pend_reg <= 1'b0;
			end
			if (restart)
				dly_cnt_reg <= 16'h0;
			else if (mon_reg == MON_DELAY && low_power_rc_oscillator_tick)
				dly_cnt_reg <= 16'(dly_cnt_reg + 16'h1);
			// Window spans whole RC ticks, so edges are never missed
			if (primary_oscillator_tick || mon_reg != MON_WATCH)
				win_cnt_reg <= 16'h0;
			else if (low_power_rc_oscillator_tick)
				win_cnt_reg <= 16'(win_cnt_reg + 16'h1);
		end
	end

	// USB PLL lock and clock selection
	always_ff @(posedge mclk) begin
		if (srst) begin
			lock_cnt_reg <= 16'h0;
			lock_reg     <= 1'b0;
			usb_reg      <= '{src: USB_SRC_FRC, pll_div2: 1'b0, wake: 1'b0};
		end else begin
			if (!pll_in) begin
				lock_cnt_reg <= 16'h0;
				lock_reg     <= 1'b0;
			end else if (lock_cnt_reg >= 16'(LOCK_CYC))
				lock_reg <= 1'b1;
			else
				lock_cnt_reg <= 16'(lock_cnt_reg + 16'h1);
			if (usb_ok)
				usb_reg.src <= pucfm_usb_src_t'(usb_sel);
			usb_reg.pll_div2 <= usb_ok ? (usb_sel == USB_SRC_PLL) :
				usb_reg.pll_div2;
			usb_reg.wake <= usb_suspend && urc_reg && usb_activity;
		end
	end

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign pb_clk_en = pb_en_reg;
	assign cpu_stall = stall_reg;
	assign sys_src   = current_osc_select_reg;
	assign usb_out   = usb_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Sync reset: at the release edge srst is already low, so guard those attempts

	pb_ratio_a: assert property (
		(pb_en_reg && pb_div_reg == 2'h2) ##1 (pb_div_reg == 2'h2)[*4] |-> pb_en_reg)
		else $error("pb enable not every 4 cycles at ratio 1:4");
	pb_equal_a: assert property (!srst && pb_div_reg == 2'h0 |=> pb_en_reg)
		else $error("pb enable missing at 1:1");
	stall_req_a: assert property (
		pb_access && pb_busy && pb_div_reg != 2'h0 |=> cpu_stall)
		else $error("back-to-back access not stalled");
	stall_none_a: assert property (pb_div_reg == 2'h0 |=> !cpu_stall)
		else $error("stall at 1:1 ratio");
	usb_norc_a: assert property (
		!srst && !usb_suspend ##1 !usb_suspend |-> usb_out.src != USB_SRC_FRC)
		else $error("USB on RC clock outside suspend");
	lock_clear_a: assert property (!pll_in |=> !lock_reg)
		else $error("lock flag set without PLL source");
	fail_switch_a: assert property (
		mon_fail |=> current_osc_select_reg == OSC_FRC && cf_reg && !swreq_reg)
		else $error("failure actions incomplete");
	fail_irq_a: assert property (mon_fail && !irqe_reg |=> irqf_reg)
		else $error("irq flag not set on failure");
	fail_stay_a: assert property (
		mon_reg == MON_FAILED |=> (current_osc_select_reg == OSC_FRC)[*2])
		else $error("left RC after failure");
	two_speed_a: assert property (ts_done && !restart |=> current_osc_select_reg == $past(dflt_osc))
		else $error("no switch to primary after start-up");
	delay_fail_a: assert property (
		mon_reg == MON_DELAY && dly_done && !primary_oscillator_stable |=> mon_reg == MON_FAILED)
		else $error("delay expiry did not fail");
	window_fail_a: assert property (
		mon_reg == MON_WATCH && mon_en && cur_primary_oscillator && win_done |=> cf_reg)
		else $error("missing primary edge not flagged");

	pb_gap_a: assert property (pb_en_reg |-> ##[1:8] pb_en_reg)
		else $error("pb enable gap longer than 8 cycles");

	lock_set_a: assert property (pll_in && lock_cnt_reg >= 16'(LOCK_CYC) |=> lock_reg)
		else $error("lock flag not set after lock delay");

	swreq_off_a: assert property (!sw_en |=> !swreq_reg)
		else $error("switch request set with switching off");

	usb_wake_a: assert property (usb_suspend && urc_reg && usb_activity |=> usb_out.wake)
		else $error("USB wake not flagged in suspend");

	fail_noirq_a: assert property (mon_fail && !irqe_reg |=> current_osc_select_reg == OSC_FRC)
		else $error("switch skipped with irq enable clear");

	ts_start_a: assert property (
		restart && two_spd && !mon_fail && mon_reg != MON_FAILED |=> current_osc_select_reg == OSC_FRC)
		else $error("two-speed start not on RC");

	delay_start_a: assert property (
		mon_reg == MON_OFF && restart && use_dly |=> mon_reg == MON_DELAY)
		else $error("monitor start delay not applied");

	fail_seen_c: cover property (mon_fail ##1 irqf_reg);
	ts_seen_c: cover property (ts_done ##1 cur_primary_oscillator);
	stall_seen_c: cover property (cpu_stall ##[1:20] !cpu_stall);
	lock_seen_c: cover property ($rose(lock_reg));
	delay_fail_c: cover property (mon_reg == MON_DELAY ##1 mon_reg == MON_FAILED);
endmodule
`default_nettype wire
